// ===== src/codec_event_flag_status.sv
// codec status registers: driver status, latched and live event flags
`timescale 1ns/1ps
module codec_event_flag_status
  import codec_flag_pkg::*;
(
  input  wire logic       clk_sys,        // system clock, 40 MHz
  input  wire logic       rst_n,          // synchronous reset, active low
  input  wire logic [7:0] regPage,        // selected register page
  input  wire logic [7:0] regAddr,        // register address within page
  input  wire logic       regRd,          // read strobe, one cycle
  input  wire logic       regWr,          // write strobe, one cycle
  input  wire logic [7:0] regWdata,       // write data, not stored
  output logic      [7:0] regRdata_q,     // read data, valid with regRvalid_q
  output logic            regRvalid_q,    // read data valid pulse
  input  wire logic [3:0] shortDetect,    // 3 left headphone, 2 right headphone, 1 left common, 0 right common
  input  wire logic [1:0] comPowerUp,     // 1 left common driver, 0 right common driver powered
  input  wire logic       buttonPress,    // headset button pressed
  input  wire logic       headsetPresent, // headset present
  input  wire logic [1:0] noiseLow        // 1 left, 0 right signal below noise threshold
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------

  // match a page 0 register read
  function automatic logic readOf(input logic [7:0] page, input logic [7:0] addr,
                                  input logic rd, input logic [7:0] target);
    readOf = rd & (page == PageZero) & (addr == target);
  endfunction : readOf

  logic readLatched;
  logic readButtonClr;
  logic unusedWrite;

  // reads that carry clearing side effects
  assign readLatched   = readOf(regPage, regAddr, regRd, AddrLatchedFlags);
  assign readButtonClr = readOf(regPage, regAddr, regRd, AddrButtonClear);
  // writes to these registers have no effect on any state
  assign unusedWrite   = regWr & (|regWdata);

  // ---------------------------------------------------------------
  // event sources
  // ---------------------------------------------------------------
  logic headsetPrev_q;
  logic headsetChange;
  logic [7:0] latchSet;
  logic [7:0] latched;

  // remember previous headset level to spot insertion or removal
  // the same flop is the live headset bit, one cycle behind the pin
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      headsetPrev_q <= 1'b0;
    else
      headsetPrev_q <= headsetPresent;
  end

  assign headsetChange = headsetPresent ^ headsetPrev_q;

  // set terms of the latched register, live conditions held high keep the bit
  always_comb
  begin
    latchSet = FlagRegReset;
    latchSet[ShortFieldLsb +: 4] = shortDetect;
    latchSet[ButtonBit]          = buttonPress;
    latchSet[HeadsetBit]         = headsetChange;
    latchSet[NoiseFieldLsb +: 2] = noiseLow;
  end

  // ---------------------------------------------------------------
  // latched flags: one sticky cell per bit
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : gLatch
      sticky_flag_bit uCell (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .setIn   (latchSet[gi]),
        .clearIn (readLatched),
        .flag_q  (latched[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // live flags and driver status
  // ---------------------------------------------------------------
  logic [3:0] shortNow_q;   // driver shorts as of the last edge
  logic [1:0] powerNow_q;   // common driver power as of the last edge
  logic [1:0] noiseNow_q;   // noise-gate state as of the last edge
  logic       buttonHeld_q; // sticky button bit of the live register
  logic       buttonHeld_d;
  logic [7:0] liveView;     // live register as read
  logic [7:0] statusView;   // driver status register as read

  // driver short copy, shared by the status and live registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      shortNow_q <= FlagRegReset[ShortFieldLsb +: 4];
    else
      shortNow_q <= shortDetect;
  end

  // common driver power copy
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      powerNow_q <= FlagRegReset[PowerFieldLsb +: 2];
    else
      powerNow_q <= comPowerUp;
  end

  // noise-gate copy, followed without latching
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      noiseNow_q <= FlagRegReset[NoiseFieldLsb +: 2];
    else
      noiseNow_q <= noiseLow;
  end

  // only the live button bit is sticky; a press in the clearing cycle wins
  always_comb
  begin
    buttonHeld_d = buttonPress | (buttonHeld_q & ~readButtonClr);
  end

  // sticky button storage
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      buttonHeld_q <= FlagRegReset[ButtonBit];
    else
      buttonHeld_q <= buttonHeld_d;
  end

  // live register as read, levels one cycle behind the inputs
  always_comb
  begin
    liveView = FlagRegReset;
    liveView[ShortFieldLsb +: 4] = shortNow_q;
    liveView[ButtonBit]          = buttonHeld_q;
    liveView[HeadsetBit]         = headsetPrev_q;
    liveView[NoiseFieldLsb +: 2] = noiseNow_q;
  end

  // driver short and common power status, reserved low bits fixed
  always_comb
  begin
    statusView = FlagRegReset;
    statusView[ShortFieldLsb +: 4] = shortNow_q;
    statusView[PowerFieldLsb +: 2] = powerNow_q;
    statusView[1:0]                = ReservedStatusBits;
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [7:0] readMux;

  // select the addressed register, unmapped reads return zero
  always_comb
  begin
    readMux = UnmappedReadValue;
    if (regPage == PageZero)
    begin
      case (regAddr)
        AddrDriverStatus: readMux = statusView;
        AddrLatchedFlags: readMux = latched;                                 // value before the clear
        AddrLiveFlags:    readMux = liveView;
        default:          readMux = UnmappedReadValue;
      endcase
    end
  end

  // register read data one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      regRdata_q <= UnmappedReadValue;
    else if (regRd)
      regRdata_q <= readMux;
  end

  // read valid pulse
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      regRvalid_q <= 1'b0;
    else
      regRvalid_q <= regRd;
  end

endmodule : codec_event_flag_status

// ===== src/codec_flag_pkg.sv
// constants shared by the codec event flag and status logic
package codec_flag_pkg;

  // ---------------------------------------------------------------
  // register map, page 0
  // ---------------------------------------------------------------
  localparam logic [7:0] PageZero            = 8'h00;
  localparam logic [7:0] AddrDriverStatus    = 8'h5f; // driver_fault_power_status
  localparam logic [7:0] AddrLatchedFlags    = 8'h60; // latched_event_flags
  localparam logic [7:0] AddrLiveFlags       = 8'h61; // live_event_flags
  localparam logic [7:0] AddrButtonClear     = 8'h0e; // register 14, clears live button bit

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         ShortFieldLsb       = 4;     // short-circuit bits 7..4
  localparam int         PowerFieldLsb       = 2;     // common driver power bits 3..2
  localparam int         ButtonBit           = 3;
  localparam int         HeadsetBit          = 2;
  localparam int         NoiseFieldLsb       = 0;     // noise-gate bits 1..0
  localparam logic [1:0] ReservedStatusBits  = 2'h0;
  localparam logic [7:0] FlagRegReset        = 8'h00;
  localparam logic [7:0] UnmappedReadValue   = 8'h00;

endpackage : codec_flag_pkg

// ===== src/sticky_flag_bit.sv
// one sticky flag cell: set wins over clear
`timescale 1ns/1ps
module sticky_flag_bit
  import codec_flag_pkg::*;
(
  input  wire logic clk_sys, // system clock
  input  wire logic rst_n,   // synchronous reset, active low
  input  wire logic setIn,   // event or live condition
  input  wire logic clearIn, // clearing read strobe
  output logic      flag_q   // latched flag
);

  logic flag_d;

  // hold until cleared; a set in the clearing cycle keeps the flag
  always_comb
  begin
    flag_d = setIn | (flag_q & ~clearIn);
  end

  // flag storage
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

endmodule : sticky_flag_bit

// ===== tb/codec_event_flag_status_props.sv
// assertions on the codec status register ports
`timescale 1ns/1ps
module codec_event_flag_status_props
  import codec_flag_pkg::*;
(
  input wire logic       clk_sys,        // clock
  input wire logic       rst_n,          // reset, active low
  input wire logic [7:0] regPage,        // page
  input wire logic [7:0] regAddr,        // address
  input wire logic       regRd,          // read strobe
  input wire logic [7:0] regRdata_q,     // read data
  input wire logic       regRvalid_q,    // read valid
  input wire logic [3:0] shortDetect,    // shorts
  input wire logic [1:0] comPowerUp,     // power
  input wire logic       buttonPress,    // button
  input wire logic       headsetPresent, // headset
  input wire logic [1:0] noiseLow        // noise gate
);
  logic [1:0] up_q;   // reset history
  logic       seen_q; // read last cycle
  logic [7:0] sel_q;  // address of that read
  logic       rdSt, rdLt, rdLv;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // remember each read and how long reset has been away
  always_ff @(posedge clk_sys)
  begin
    up_q   <= {up_q[0], rst_n};
    seen_q <= regRd & rst_n;
    sel_q  <= (regPage == PageZero) ? regAddr : 8'hff;
  end
  // data cycle of a read whose register saw no reset
  assign rdSt = seen_q && up_q[1] && sel_q == AddrDriverStatus;
  assign rdLt = seen_q && up_q[1] && sel_q == AddrLatchedFlags;
  assign rdLv = seen_q && up_q[1] && sel_q == AddrLiveFlags;
  a_rvalid_pulse: assert property (up_q[0] |-> regRvalid_q == $past(regRd))
    else $error("read valid wrong");
  a_status_shorts: assert property (rdSt |-> regRdata_q[7:4] == $past(shortDetect, 2))
    else $error("status short bits wrong");
  a_status_power: assert property (rdSt |-> regRdata_q[3:2] == $past(comPowerUp, 2))
    else $error("status power bits wrong");
  a_status_reserved: assert property (rdSt |-> regRdata_q[1:0] == ReservedStatusBits)
    else $error("status low bits not zero");
  a_live_shorts: assert property (rdLv |-> regRdata_q[7:4] == $past(shortDetect, 2))
    else $error("live short bits wrong");
  a_live_headset: assert property (rdLv |-> regRdata_q[2] == $past(headsetPresent, 2))
    else $error("live headset bit wrong");
  a_live_noise: assert property (rdLv |-> regRdata_q[1:0] == $past(noiseLow, 2))
    else $error("live noise bits wrong");
  a_latch_catch: assert property (rdLt |-> ({$past(shortDetect, 2), $past(buttonPress, 2),
    1'b0, $past(noiseLow, 2)} & ~regRdata_q) == 8'h00) else $error("latched event lost");
  a_clear_keep: assert property (rdLt && $past(rdLt) |-> regRdata_q[7:4] == $past(shortDetect, 2))
    else $error("clearing read wrong");
endmodule : codec_event_flag_status_props
bind codec_event_flag_status codec_event_flag_status_props codec_event_flag_status_props_inst (
  .clk_sys        (clk_sys),
  .rst_n          (rst_n),
  .regPage        (regPage),
  .regAddr        (regAddr),
  .regRd          (regRd),
  .regRdata_q     (regRdata_q),
  .regRvalid_q    (regRvalid_q),
  .shortDetect    (shortDetect),
  .comPowerUp     (comPowerUp),
  .buttonPress    (buttonPress),
  .headsetPresent (headsetPresent),
  .noiseLow       (noiseLow)
);

// ===== tb/codec_event_flag_status_bench.sv
// self-checking bench for the codec status registers
`timescale 1ns/1ps
module codec_event_flag_status_bench
  import codec_flag_pkg::*;
;
  logic       clk_sys, rst_n, regRd, regWr, regRvalid_q, buttonPress, headsetPresent;
  logic [7:0] regPage, regAddr, regWdata, regRdata_q;
  logic [3:0] shortDetect;
  logic [1:0] comPowerUp, noiseLow;
  int         error_cnt, checked, cycles;
  logic [7:0] regs [3] = '{AddrDriverStatus, AddrLatchedFlags, AddrLiveFlags};
  codec_event_flag_status codec_event_flag_status_inst (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .regPage        (regPage),
    .regAddr        (regAddr),
    .regRd          (regRd),
    .regWr          (regWr),
    .regWdata       (regWdata),
    .regRdata_q     (regRdata_q),
    .regRvalid_q    (regRvalid_q),
    .shortDetect    (shortDetect),
    .comPowerUp     (comPowerUp),
    .buttonPress    (buttonPress),
    .headsetPresent (headsetPresent),
    .noiseLow       (noiseLow)
  );
  // compare one byte
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one read; strobe stays high so reads run back to back
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    regWr   = 1'b0;
    regRd   = 1'b1;
    regAddr = addr;
    @(negedge clk_sys);
    chk("valid", 8'h01, {7'h00, regRvalid_q});
    chk("rdata", exp, regRdata_q);
  endtask : rd
  // one write of all ones; the strobe stays up for a following write
  task automatic wr(input logic [7:0] addr);
    regRd    = 1'b0;
    regWr    = 1'b1;
    regAddr  = addr;
    regWdata = 8'hff;
    @(negedge clk_sys);
  endtask : wr
  // set the detector inputs and let the registers catch up
  task automatic put(input logic [9:0] v);
    regRd = 1'b0;
    regWr = 1'b0;
    {shortDetect, comPowerUp, buttonPress, headsetPresent, noiseLow} = v;
    repeat (2) @(negedge clk_sys);
  endtask : put
  task automatic close_out();
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // cut a hang short
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 500)
    begin
      error_cnt++;
      close_out();
    end
  end
  // test sequence
  initial
  begin
    {rst_n, regRd, regWr, regPage, regAddr, regWdata} = '0;
    {shortDetect, comPowerUp, buttonPress, headsetPresent, noiseLow} = '0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    foreach (regs[i]) rd(regs[i], FlagRegReset);
    foreach (regs[i])
      if (regs[i] != AddrDriverStatus)
        wr(regs[i]); // status register never written
    foreach (regs[i]) rd(regs[i], FlagRegReset);
    regPage = 8'h01;
    rd(AddrLiveFlags, UnmappedReadValue);
    regPage = PageZero;
    $display("test reset done");
    put({4'ha, 2'b10, 4'h0});
    rd(AddrDriverStatus, 8'ha8);
    put({4'h5, 2'b01, 4'h0});
    rd(AddrDriverStatus, 8'h54);
    rd(AddrLatchedFlags, 8'hf0);
    rd(AddrLiveFlags, 8'h50);
    rd(AddrLatchedFlags, 8'h50);
    put(10'h000);
    rd(AddrLatchedFlags, 8'h50);
    rd(AddrLatchedFlags, 8'h00);
    $display("test status done");
    put({4'h9, 2'b00, 1'b1, 1'b1, 2'b11});
    rd(AddrLiveFlags, 8'h9f);
    rd(AddrLatchedFlags, 8'h9f);
    rd(AddrLatchedFlags, 8'h9b);
    put(10'h000);
    rd(AddrLatchedFlags, 8'h9f);
    rd(AddrLatchedFlags, 8'h00);
    rd(AddrLiveFlags, 8'h08);
    rd(AddrButtonClear, 8'h00);
    rd(AddrLiveFlags, 8'h00);
    $display("test events done");
    put({4'h3, 2'b11, 1'b1, 1'b0, 2'b01});
    rst_n = 1'b0;
    put(10'h000);
    rst_n = 1'b1;
    foreach (regs[i]) rd(regs[i], FlagRegReset);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : codec_event_flag_status_bench
